// ===== low_power_mode_controller_tb.sv
// Self-checking bench for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_controller_tb
    import lpmc_pkg::*;
;
    logic i_clk = 1'b0, i_rst_n = 1'b0, go = 1'b0, lp_sel = 1'b0;
    logic rq, rlp, periph = 1'b0, svm = 1'b0, rtc = 1'b0, usb = 1'b0;
    logic pin = 1'b0, wdg = 1'b0, xrst_n = 1'b1, we = 1'b0;
    logic cpu_en, core_en, pll, rc, xtal, ron, rlpo, ret, crst_n, rtcw;
    logic [1:0] md = 2'h0, msel;
    logic [15:0] ext = 16'h0, wd = 16'h0, rd;
    logic [5:0] ad = 6'h0;
    logic [4:0] st;
    logic [15:0] bk [0:2];
    logic [5:0] ba [0:2] = '{6'h00, 6'h29, 6'h11};
    int n_errors = 0, checks_done = 0;

    always #2.5 i_clk = ~i_clk;

    lpmc_top u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_lp_req(rq),
        .i_mode_sel(msel), .i_regulator_lp_sel(rlp),
        .i_periph_event(periph), .i_ext_line(ext),
        .i_supply_voltage_monitor(svm), .i_rtc_alarm(rtc),
        .i_usb_wakeup(usb), .i_wakeup_pin(pin),
        .i_independent_watchdog_rst(wdg), .i_external_reset_pin_n(xrst_n),
        .i_bkp_we(we), .i_bkp_addr(ad), .i_bkp_wdata(wd), .o_bkp_rdata(rd),
        .o_cpu_clk_en(cpu_en), .o_core_clk_en(core_en), .o_pll_en(pll),
        .o_internal_rc_oscillator_en(rc),
        .o_external_crystal_oscillator_en(xtal), .o_regulator_on(ron),
        .o_regulator_lp(rlpo), .o_core_retain(ret), .o_core_rst_n(crst_n),
        .o_rtc_wdg_clk_en(rtcw), .o_state(st));

    lpmc_cpu_model u_cpu (.i_clk(i_clk), .i_go(go), .i_mode(md),
        .i_lp(lp_sel), .i_state(st), .o_lp_req(rq), .o_mode_sel(msel),
        .o_regulator_lp_sel(rlp));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task end_sim;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Bounded wait; returns the cycles taken
    task wait_st(input logic [4:0] s, output int n);
        n = 0;
        while (st !== s)
        begin
            if (n == 60)
            begin
                n_errors++;
                $display("unexpected at %0t: state wait timed out", $time);
                end_sim();
            end
            tick(1);
            n++;
        end
    endtask

    function automatic logic [4:0] exp_st(input logic [1:0] m);
        if (m == LPMC_SEL_STOP)
            return 5'h04;
        return (m == LPMC_SEL_STANDBY) ? 5'h08 : 5'h02;
    endfunction

    // Source numbering wraps per mode so random indices stay legal
    task src_set(input logic [1:0] m, input int s, input logic v);
        int k;
        k = s % ((m == LPMC_SEL_STOP) ? 19 : 20);
        if (m == LPMC_SEL_STANDBY)
            case (s % 4)
                0: xrst_n = ~v;
                1: wdg = v;
                2: pin = v;
                default: rtc = v;
            endcase
        else
            case (k)
                16: svm = v;
                17: rtc = v;
                18: usb = v;
                19: periph = v;
                default: ext[k[3:0]] = v;
            endcase
    endtask

    task run_mode(input logic [1:0] m, input logic lp, input int s);
        int n;
        md = m;
        lp_sel = lp;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        wait_st(exp_st(m), n);
        tick(2);
        chk(16'(st), 16'(exp_st(m)), "entry state");
        chk(16'(rtcw), 16'h1, "rtc clock");
        if (m == LPMC_SEL_STOP)
        begin
            chk(16'({core_en, pll, rc, xtal}), 16'h0, "stop clocks");
            chk(16'({ron, rlpo}), 16'({1'b1, lp}), "regulator");
            chk(16'(ret), 16'h1, "retain");
            periph = 1'b1;
            tick(2);
            periph = 1'b0;
            chk(16'(st), 16'h4, "stop left on periph");
        end
        else if (m == LPMC_SEL_STANDBY)
        begin
            chk(16'(ron), 16'h0, "regulator on");
            chk(16'({pll, rc, xtal}), 16'h0, "oscillators");
            chk(16'(crst_n), 16'h0, "core reset");
            pin = 1'b0;
            tick(1);
        end
        else
            chk(16'({cpu_en, core_en}), 16'h1, "sleep clocks");
        src_set(m, s, 1'b1);
        wait_st((m == LPMC_SEL_STANDBY) ? 5'h10 : 5'h01, n);
        chk(16'(n), 16'h1, "wake latency");
        src_set(m, s, 1'b0);
        if (m == LPMC_SEL_STANDBY)
        begin
            chk(16'({crst_n, ron, rc}), 16'h3, "power-up");
            wait_st(5'h01, n);
            chk(16'(n), 16'h15, "power-up length");
        end
        chk(16'({cpu_en, core_en, rc, rlpo, crst_n}), 16'h1D, "run");
    endtask

    task bkp_rd(input logic [5:0] a, input logic [15:0] e);
        ad = a;
        tick(2);
        chk(rd, e, "backup read");
    endtask

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial
    begin
        int n;
        void'($urandom(32'h8f090538));
        tick(12);
        i_rst_n = 1'b1;
        wait_st(5'h01, n);
        chk(16'({rtcw, crst_n}), 16'h3, "after power-up");
        for (int i = 0; i < 3; i++)
        begin
            bk[i] = 16'($urandom);
            ad = ba[i];
            wd = bk[i];
            we = 1'b1;
            tick(1);
            we = 1'b0;
        end
        for (int s = 0; s < 20; s++)
            run_mode(LPMC_SEL_SLEEP, 1'b0, s);
        run_mode(2'h3, 1'b0, 19);
        for (int s = 0; s < 19; s++)
            run_mode(LPMC_SEL_STOP, s[0], s);
        // Pin already high on entry must not count as an edge
        pin = 1'b1;
        for (int s = 2; s < 6; s++)
            run_mode(LPMC_SEL_STANDBY, 1'b0, s);
        bkp_rd(6'h2A, 16'h0);
        i_rst_n = 1'b0;
        tick(3);
        i_rst_n = 1'b1;
        wait_st(5'h01, n);
        for (int i = 0; i < 3; i++)
            bkp_rd(ba[i], bk[i]);
        repeat (30)
            run_mode(2'($urandom_range(3)), 1'($urandom), $urandom_range(39));
        end_sim();
    end
endmodule
`default_nettype wire

// ===== lpmc_bkp_mem.sv
// Always-on backup register bank, not touched by any reset
`timescale 1ns/1ps
`default_nettype none
module lpmc_bkp_mem
    import lpmc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [LPMC_BKP_ADDR_W-1:0] i_addr,
    input wire logic [LPMC_BKP_DATA_W-1:0] i_wdata,
    output logic [LPMC_BKP_DATA_W-1:0] o_rdata
);
    logic [LPMC_BKP_DATA_W-1:0] mem [LPMC_BKP_REGS];

    // No reset on purpose: contents survive every reset and standby exit
    always_ff @(posedge i_clk)
    begin
        if (i_we && (int'(i_addr) < LPMC_BKP_REGS))
        begin
            mem[i_addr] <= i_wdata;
        end
        if (int'(i_addr) < LPMC_BKP_REGS)
        begin
            o_rdata <= mem[i_addr];
        end
        else
        begin
            o_rdata <= LPMC_BKP_RST;
        end
    end
endmodule
`default_nettype wire

// ===== lpmc_cpu_model.sv
// Processor-side model that requests low-power entry
`timescale 1ns/1ps
`default_nettype none
module lpmc_cpu_model
(
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [1:0] i_mode,
    input wire logic i_lp,
    input wire logic [4:0] i_state,
    output logic o_lp_req,
    output logic [1:0] o_mode_sel,
    output logic o_regulator_lp_sel
);
    logic armed = 1'b0;
    initial
    begin
        o_lp_req = 1'b0;
        o_mode_sel = 2'h0;
        o_regulator_lp_sel = 1'b0;
    end
    // Mode and regulator are settled a cycle before the request
    always @(posedge i_clk)
    begin
        o_lp_req <= 1'b0;
        if (i_go)
        begin
            o_mode_sel <= i_mode;
            o_regulator_lp_sel <= i_lp;
            armed <= 1'b1;
        end
        else if (armed && i_state == 5'h01)
        begin
            o_lp_req <= 1'b1;
            armed <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== lpmc_pkg.sv
// Package of constants and types for the low-power mode controller
package lpmc_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int LPMC_EXT_LINES = 16;
    localparam int LPMC_BKP_REGS = 42;
    localparam int LPMC_BKP_ADDR_W = 6;
    localparam int LPMC_BKP_DATA_W = 16;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam int LPMC_CLK_MHZ = 200;
    localparam int LPMC_POR_NS = 100;
    localparam int LPMC_POR_CYCLES = (LPMC_POR_NS * LPMC_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] LPMC_POR_CNT = LPMC_POR_CYCLES[7:0];
    localparam logic [7:0] LPMC_CNT_RST = 8'h00;
    localparam logic [15:0] LPMC_BKP_RST = 16'h0000;

    // ------------------------------------------------------------
    // Mode selection codes
    // ------------------------------------------------------------
    localparam logic [1:0] LPMC_SEL_SLEEP = 2'h0;
    localparam logic [1:0] LPMC_SEL_STOP = 2'h1;
    localparam logic [1:0] LPMC_SEL_STANDBY = 2'h2;

    typedef enum logic [4:0] {
        LPMC_RUN = 5'h01,
        LPMC_SLEEP = 5'h02,
        LPMC_STOP = 5'h04,
        LPMC_STANDBY = 5'h08,
        LPMC_POWERUP = 5'h10
    } lpmc_state_type;

endpackage

// ===== lpmc_top.sv
// Low-power mode controller: sleep, stop and standby sequencing
// Function
// - The lightest state halts only the processor clock; peripherals keep running.
// - Any peripheral interrupt or event resumes the processor from the lightest state.
// - The intermediate state keeps static memory and register contents.
// - The intermediate state gates core-domain clocks and turns off PLL and both oscillators.
// - A setting picks normal or low-power regulator operation during the intermediate state.
// - Any active external event line ends the intermediate state.
// - Event lines are sixteen pins, supply monitor, clock alarm and USB wakeup.
// - The deepest state switches the regulator off, unpowering the core domain.
// - The deepest state turns off the PLL and both oscillators.
// - After the deepest state only backup registers and standby logic keep values.
// - Reset pin, watchdog reset, wakeup pin rising edge or clock alarm end the deepest state.
// - Stop and standby never halt the clock, the watchdog or their clock sources.
// - The backup bank holds 16-bit registers surviving all resets and standby.
`timescale 1ns/1ps
`default_nettype none
module lpmc_top
    import lpmc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_lp_req,
    input wire logic [1:0] i_mode_sel,
    input wire logic i_regulator_lp_sel,
    input wire logic i_periph_event,
    input wire logic [LPMC_EXT_LINES-1:0] i_ext_line,
    input wire logic i_supply_voltage_monitor,
    input wire logic i_rtc_alarm,
    input wire logic i_usb_wakeup,
    input wire logic i_wakeup_pin,
    input wire logic i_independent_watchdog_rst,
    input wire logic i_external_reset_pin_n,
    input wire logic i_bkp_we,
    input wire logic [LPMC_BKP_ADDR_W-1:0] i_bkp_addr,
    input wire logic [LPMC_BKP_DATA_W-1:0] i_bkp_wdata,
    output logic [LPMC_BKP_DATA_W-1:0] o_bkp_rdata,
    output logic o_cpu_clk_en,
    output logic o_core_clk_en,
    output logic o_pll_en,
    output logic o_internal_rc_oscillator_en,
    output logic o_external_crystal_oscillator_en,
    output logic o_regulator_on,
    output logic o_regulator_lp,
    output logic o_core_retain,
    output logic o_core_rst_n,
    output logic o_rtc_wdg_clk_en,
    output logic [4:0] o_state
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_n;
    logic rst_n;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        lpmc_state_type st;
        logic [7:0] cnt;
        logic wakeup_pin_prev;
        logic cpu_clk_en;
        logic core_clk_en;
        logic pll_en;
        logic rc_en;
        logic xtal_en;
        logic reg_on;
        logic reg_lp;
        logic retain;
        logic core_rst_n;
    } lpmc_regs_type;

    localparam lpmc_regs_type LPMC_REGS_RST = '{
        st: LPMC_POWERUP, cnt: LPMC_CNT_RST, wakeup_pin_prev: 1'b0,
        cpu_clk_en: 1'b0, core_clk_en: 1'b0, pll_en: 1'b0,
        rc_en: 1'b1, xtal_en: 1'b0, reg_on: 1'b1, reg_lp: 1'b0,
        retain: 1'b0, core_rst_n: 1'b0};

    lpmc_regs_type r;
    lpmc_regs_type next_r;

    logic stop_wake;
    logic standby_wake;

    always_comb
    begin
        stop_wake = (|i_ext_line) | i_supply_voltage_monitor |
                    i_rtc_alarm | i_usb_wakeup;
        standby_wake = !i_external_reset_pin_n | i_independent_watchdog_rst |
                       (i_wakeup_pin & !r.wakeup_pin_prev) | i_rtc_alarm;
    end

    always_comb
    begin
        next_r = r;
        next_r.wakeup_pin_prev = i_wakeup_pin;
        unique case (r.st)
            LPMC_RUN:
            begin
                if (i_lp_req)
                begin
                    if (i_mode_sel == LPMC_SEL_STOP)
                    begin
                        next_r.st = LPMC_STOP;
                        next_r.cpu_clk_en = 1'b0;
                        next_r.core_clk_en = 1'b0;
                        next_r.pll_en = 1'b0;
                        next_r.rc_en = 1'b0;
                        next_r.xtal_en = 1'b0;
                        next_r.reg_lp = i_regulator_lp_sel;
                        next_r.retain = 1'b1;
                    end
                    else if (i_mode_sel == LPMC_SEL_STANDBY)
                    begin
                        next_r.st = LPMC_STANDBY;
                        next_r.cpu_clk_en = 1'b0;
                        next_r.core_clk_en = 1'b0;
                        next_r.pll_en = 1'b0;
                        next_r.rc_en = 1'b0;
                        next_r.xtal_en = 1'b0;
                        next_r.reg_on = 1'b0;
                        next_r.retain = 1'b0;
                        next_r.core_rst_n = 1'b0;
                    end
                    else
                    begin
                        next_r.st = LPMC_SLEEP;
                        next_r.cpu_clk_en = 1'b0;
                    end
                end
            end
            LPMC_SLEEP:
            begin
                if (i_periph_event | stop_wake)
                begin
                    next_r.st = LPMC_RUN;
                    next_r.cpu_clk_en = 1'b1;
                end
            end
            LPMC_STOP:
            begin
                if (stop_wake)
                begin
                    next_r.st = LPMC_RUN;
                    next_r.cpu_clk_en = 1'b1;
                    next_r.core_clk_en = 1'b1;
                    next_r.rc_en = 1'b1;
                    next_r.reg_lp = 1'b0;
                    next_r.retain = 1'b0;
                end
            end
            LPMC_STANDBY:
            begin
                if (standby_wake)
                begin
                    // Core state is gone, so restart like a power-up
                    next_r.st = LPMC_POWERUP;
                    next_r.reg_on = 1'b1;
                    next_r.rc_en = 1'b1;
                    next_r.cnt = LPMC_CNT_RST;
                end
            end
            LPMC_POWERUP:
            begin
                if (r.cnt >= LPMC_POR_CNT)
                begin
                    next_r.st = LPMC_RUN;
                    next_r.core_rst_n = 1'b1;
                    next_r.cpu_clk_en = 1'b1;
                    next_r.core_clk_en = 1'b1;
                end
                else
                begin
                    next_r.cnt = r.cnt + 8'h01;
                end
            end
            default:
            begin
                next_r = LPMC_REGS_RST;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= LPMC_REGS_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Backup bank and outputs
    // ------------------------------------------------------------
    lpmc_bkp_mem u_bkp (
        .i_clk(i_clk),
        .i_we(i_bkp_we),
        .i_addr(i_bkp_addr),
        .i_wdata(i_bkp_wdata),
        .o_rdata(o_bkp_rdata)
    );

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_rtc_wdg_clk_en <= 1'b0;
        end
        else
        begin
            o_rtc_wdg_clk_en <= 1'b1;
        end
    end

    always_comb
    begin
        o_cpu_clk_en = r.cpu_clk_en;
        o_core_clk_en = r.core_clk_en;
        o_pll_en = r.pll_en;
        o_internal_rc_oscillator_en = r.rc_en;
        o_external_crystal_oscillator_en = r.xtal_en;
        o_regulator_on = r.reg_on;
        o_regulator_lp = r.reg_lp;
        o_core_retain = r.retain;
        o_core_rst_n = r.core_rst_n;
        o_state = r.st;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);
    property p_sleep_core;
        (r.st == LPMC_SLEEP) |-> (o_core_clk_en && !o_cpu_clk_en);
    endproperty
    a_sleep_core: assert property (p_sleep_core)
        else $error("sleep stopped core clocks");
    property p_sleep_wake;
        (r.st == LPMC_SLEEP && i_periph_event) |=> o_cpu_clk_en;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake)
        else $error("sleep did not wake");
    property p_stop_retain;
        (r.st == LPMC_STOP) |-> (o_core_retain && o_regulator_on);
    endproperty
    a_stop_retain: assert property (p_stop_retain)
        else $error("stop lost retention");
    property p_stop_clocks;
        (r.st == LPMC_STOP) |-> !(o_core_clk_en | o_pll_en |
            o_internal_rc_oscillator_en | o_external_crystal_oscillator_en);
    endproperty
    a_stop_clocks: assert property (p_stop_clocks)
        else $error("stop left a clock running");
    property p_stop_reg;
        (r.st == LPMC_RUN && i_lp_req && i_mode_sel == LPMC_SEL_STOP)
            |=> (o_regulator_lp == $past(i_regulator_lp_sel));
    endproperty
    a_stop_reg: assert property (p_stop_reg)
        else $error("regulator mode not taken");
    property p_stop_wake;
        (r.st == LPMC_STOP && stop_wake) |=> (r.st == LPMC_RUN);
    endproperty
    a_stop_wake: assert property (p_stop_wake)
        else $error("stop did not wake");
    property p_standby_off;
        (r.st == LPMC_STANDBY) |-> (!o_regulator_on && !o_pll_en &&
            !o_core_retain && !o_core_rst_n);
    endproperty
    a_standby_off: assert property (p_standby_off)
        else $error("standby left core powered");
    property p_standby_exit;
        (r.st == LPMC_STANDBY && standby_wake) |=>
            (r.st == LPMC_POWERUP) ##[1:30] o_core_rst_n;
    endproperty
    a_standby_exit: assert property (p_standby_exit)
        else $error("standby exit skipped power-up");

endmodule
`default_nettype wire
